// ===== bas_regs.vh
// Constants for the backplane agent cycle sequencer
`ifndef BAS_REGS_VH
`define BAS_REGS_VH

// Sequencer states
`define BAS_ST_IDLE 3'h0
`define BAS_ST_RESOLVE 3'h1
`define BAS_ST_ACQUIRE 3'h2
`define BAS_ST_REQUEST 3'h3
`define BAS_ST_OWNREPLY 3'h4
`define BAS_ST_RXREPLY 3'h5
`define BAS_ST_SIGNAL 3'h6
`define BAS_ST_RECOVER 3'h7

// Address space codes on the bus
`define BAS_SP_MEM 2'h0
`define BAS_SP_IO 2'h1
`define BAS_SP_MSG 2'h2
`define BAS_SP_ICN 2'h3

// Message space holds 255 addresses, 1 to 255
`define BAS_MSG_LAST 8'hff
`define BAS_MSG_FIRST 8'h01
// Interconnect space: slot number carried in the address
`define BAS_ICN_SLOT_MSB 15
`define BAS_ICN_SLOT_LSB 11

// Host-side windows for message and interconnect spaces
`define BAS_HOST_MSG_PAGE 24'hfffe00
`define BAS_HOST_ICN_PAGE 16'hfffd

// Timing, in ns, and clock period
`define BAS_CLK_PERIOD_NS 10
`define BAS_RESOLVE_NS 60
`define BAS_SIGNAL_NS 30
`define BAS_CNT_W 8

// Identifier capture after reset release (sync pipeline fill first)
`define BAS_ID_SLOT_CYC 2'h2
`define BAS_ID_ARB_CYC 2'h3

// Synchroniser: width and idle value (active-low lines idle high)
`define BAS_SYNC_W 51
`define BAS_SYNC_IDLE 51'h7_0000_0000_0000

// Transmit FIFO entry: data plus last flag
`define BAS_FIFO_DEPTH 32
`define BAS_DATA_W 32

`endif

// ===== bas_fifo.v
// Synchronous FIFO with valid/ready on both sides
`default_nettype none

module bas_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 32
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  localparam AW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire doPush;
  wire doPop;

  ////////////////////////////////////////////////////////////////
  // Full and empty come straight from the count, so both are exact
  assign inReady = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;
  assign outData = mem[rdPtr_ff];

  // Storage has no reset; pointers and count are the control state
  always @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  // Pointers wrap naturally, so depth must be a power of two
  always @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + 1'b1;
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // bas_fifo

`default_nettype wire

// ===== bas_sequencer.v
// Backplane bus agent: arbitration, transfer and exception sequencer
// Contract
// RL1: Agent presents memory, I/O, message and interconnect address spaces.
// RL2: Message space offers 255 addresses for inter-agent messages.
// RL3: Message blocks move at full bandwidth without processor per-word supervision.
// RL4: Interconnect space is reached by backplane slot number.
// RL5: Central services give initialization and timeout detection; may configure agents.
// RL6: Host memory window maps message and interconnect spaces; decode makes selects.
// RL7: Arbitration is resolution then acquisition; the winner starts a transfer.
// RL8: Transfer is request phase with address/control, then handshaked reply phase.
// RL9: Reply phase repeats until the owner ends the transfer.
// RL10: An exception from any agent aborts every arbitration or transfer in progress.
// RL11: Recovery lets exception lines go inactive; arbitration resumes the clock after.
// RL12: Data path is 32 bits and supports burst transfers.
// RL13: Agent asserts shared request line and samples it for other contenders. The sequencer drives it while resolving but never reads the synchronised line.
// RL14: Arbitration id driven on five lines; at reset they give slot and id.
// RL15: Parity error seen during a transfer drives the bus error line.
// RL16: Central services drive bus timeout when a cycle overruns its limit.
// RL17: After an abort, drivers release and no request until recovery ends.
// RL18: Resolution is abandoned on seeing a higher competing arbitration id.
`include "bas_regs.vh"
`default_nettype none

module bas_sequencer #(
  parameter DATA_W = `BAS_DATA_W,
  parameter FIFO_DEPTH = `BAS_FIFO_DEPTH
) (
  input wire clk,
  input wire rst_n,
  input wire sharedBusRequestNIn,
  output wire sharedBusRequestNOut,
  output wire sharedBusRequestNOe,
  input wire [4:0] arbitrationIdLinesIn,
  output wire [4:0] arbitrationIdLinesOut,
  output wire [4:0] arbitrationIdLinesOe,
  input wire busErrorNIn,
  output wire busErrorNOut,
  output wire busErrorNOe,
  input wire busTimeoutNIn,
  input wire startIn,
  input wire [1:0] spaceIn,
  input wire writeIn,
  input wire eotIn,
  input wire ownerRdyIn,
  input wire [DATA_W-1:0] adIn,
  input wire [3:0] parIn,
  output reg startOut,
  output reg [1:0] spaceOut,
  output reg writeOut,
  output reg eotOut,
  output reg ownerRdyOut,
  output reg [DATA_W-1:0] adOut,
  output wire [3:0] parOut,
  output wire ownerLinesOe,
  input wire replierRdyIn,
  output wire replierRdyOut,
  output wire replierRdyOe,
  input wire xferReq,
  input wire [DATA_W-1:0] xferAddr,
  input wire [1:0] xferSpace,
  output wire xferAck,
  input wire [DATA_W-1:0] txData,
  input wire txLast,
  input wire txValid,
  output wire txReady,
  output reg [DATA_W-1:0] rxData,
  output reg [1:0] rxSpace,
  output reg rxLast,
  output reg rxValid,
  input wire rxReady,
  input wire [DATA_W-1:0] hostAddr,
  input wire hostIo,
  output reg csMem,
  output reg csIo,
  output reg csMsg,
  output reg csIcn,
  output reg [4:0] slotId,
  output reg [4:0] arbId,
  output reg idReady,
  output reg xferDone,
  output reg exceptionSeen,
  output wire [2:0] state
);
  localparam [`BAS_CNT_W-1:0] RESOLVE_CYC =
    (`BAS_RESOLVE_NS + `BAS_CLK_PERIOD_NS - 1) / `BAS_CLK_PERIOD_NS;
  localparam [`BAS_CNT_W-1:0] SIGNAL_CYC =
    (`BAS_SIGNAL_NS + `BAS_CLK_PERIOD_NS - 1) / `BAS_CLK_PERIOD_NS;

  reg [`BAS_SYNC_W-1:0] sync1_ff;
  reg [`BAS_SYNC_W-1:0] sync2_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [`BAS_CNT_W-1:0] cnt_ff;
  reg [1:0] idCnt_ff;
  reg phase_ff;
  reg drvErr_ff;
  reg rrdy_ff;
  reg [DATA_W-1:0] addr_ff;
  wire sBreqN, sErrN, sToN, sStart, sWr, sEot, sOrdy, sRrdy;
  wire [4:0] sArb;
  wire [1:0] sSpace;
  wire [DATA_W-1:0] sAd;
  wire [3:0] sPar;
  wire [3:0] calcPar;
  wire exc;
  wire parErr;
  wire rxHit;
  wire [DATA_W:0] fifoOut;
  wire fifoValid;
  wire fifoPop;

  ////////////////////////////////////////////////////////////////
  // Every bus pin passes two flops; only the second stage is read
  always @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff <= `BAS_SYNC_IDLE;
      sync2_ff <= `BAS_SYNC_IDLE;
    end else begin
      sync1_ff <= {sharedBusRequestNIn, busErrorNIn, busTimeoutNIn, arbitrationIdLinesIn,
                   startIn, spaceIn, writeIn, eotIn, ownerRdyIn, replierRdyIn, adIn, parIn};
      sync2_ff <= sync1_ff;
    end
  end
  assign {sBreqN, sErrN, sToN, sArb, sStart, sSpace, sWr, sEot, sOrdy, sRrdy, sAd, sPar} =
    sync2_ff;

  // Byte parity, one generator per lane, shared by sending and checking
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gPar
      assign calcPar[g] = ^((state_ff == `BAS_ST_RXREPLY) ? sAd[8*g+7:8*g] : adOut[8*g+7:8*g]);
    end
  endgenerate
  assign parOut = calcPar;
  assign parErr = (calcPar != sPar);

  // Error or timeout from anyone aborts what we are doing
  assign exc = !sErrN || !sToN; // [RL10] [RL16]
  // Accept writes in our message range or interconnect slot, and any memory or I/O write
  assign rxHit = sStart && sWr && (((sSpace == `BAS_SP_MSG) &&
                 (sAd[7:0] >= `BAS_MSG_FIRST) && (sAd[7:0] <= `BAS_MSG_LAST)) || // [RL2]
                 ((sSpace == `BAS_SP_ICN) &&
                 (sAd[`BAS_ICN_SLOT_MSB:`BAS_ICN_SLOT_LSB] == slotId)) || // [RL4]
                 (sSpace == `BAS_SP_MEM) || (sSpace == `BAS_SP_IO)); // [RL1]

  ////////////////////////////////////////////////////////////////
  // Transmit words wait here; an empty FIFO stalls the reply phase
  bas_fifo #(
    .WIDTH(DATA_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .rst_n(rst_n),
    .inData({txLast, txData}),
    .inValid(txValid),
    .inReady(txReady),
    .outData(fifoOut),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );
  assign fifoPop = (state_ff == `BAS_ST_OWNREPLY) && !phase_ff && ownerRdyOut && sRrdy;

  ////////////////////////////////////////////////////////////////
  // Slot then arbitration id are read off the arbitration lines after reset
  always @(posedge clk) begin
    if (!rst_n) begin
      idCnt_ff <= 2'h0;
      slotId <= 5'h00;
      arbId <= 5'h00;
      idReady <= 1'b0;
    end else if (!idReady) begin
      idCnt_ff <= idCnt_ff + 2'h1;
      if (idCnt_ff == `BAS_ID_SLOT_CYC) begin
        slotId <= sArb; // [RL14]
      end
      if (idCnt_ff == `BAS_ID_ARB_CYC) begin
        arbId <= sArb; // [RL14]
        idReady <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Cycle sequencer; exception has priority over every other move
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `BAS_ST_IDLE: begin
        if (exc) begin
          nxt_state = `BAS_ST_SIGNAL;
        end else if (rxHit) begin
          nxt_state = `BAS_ST_RXREPLY;
        end else if (xferReq && idReady) begin
          nxt_state = `BAS_ST_RESOLVE; // [RL13]
        end
      end
      `BAS_ST_RESOLVE: begin
        if (exc) begin
          nxt_state = `BAS_ST_SIGNAL; // [RL10]
        end else if (sArb > arbId) begin
          nxt_state = `BAS_ST_IDLE; // [RL18]
        end else if (cnt_ff == RESOLVE_CYC) begin
          nxt_state = `BAS_ST_ACQUIRE; // [RL7]
        end
      end
      `BAS_ST_ACQUIRE: begin
        nxt_state = exc ? `BAS_ST_SIGNAL : `BAS_ST_REQUEST; // [RL7]
      end
      `BAS_ST_REQUEST: begin
        nxt_state = exc ? `BAS_ST_SIGNAL : `BAS_ST_OWNREPLY; // [RL8]
      end
      `BAS_ST_OWNREPLY: begin
        if (exc) begin
          nxt_state = `BAS_ST_SIGNAL;
        end else if (phase_ff && !sRrdy && eotOut) begin
          nxt_state = `BAS_ST_IDLE; // [RL9]
        end
      end
      `BAS_ST_RXREPLY: begin
        if (exc || drvErr_ff) begin
          nxt_state = `BAS_ST_SIGNAL;
        end else if (rxLast && rxValid && rxReady && !sOrdy) begin
          nxt_state = `BAS_ST_IDLE;
        end
      end
      `BAS_ST_SIGNAL: begin
        if (!drvErr_ff && cnt_ff >= SIGNAL_CYC) begin
          nxt_state = `BAS_ST_RECOVER;
        end
      end
      `BAS_ST_RECOVER: begin
        // Leave only once both exception lines are seen inactive
        if (!exc) begin
          nxt_state = `BAS_ST_IDLE; // [RL11]
        end
      end
      default: begin
        nxt_state = `BAS_ST_IDLE;
      end
    endcase
  end

  // State, counters and handshake phases
  always @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= `BAS_ST_IDLE;
      cnt_ff <= {`BAS_CNT_W{1'b0}};
      phase_ff <= 1'b0;
      drvErr_ff <= 1'b0;
      rrdy_ff <= 1'b0;
      addr_ff <= {DATA_W{1'b0}};
      xferDone <= 1'b0;
      exceptionSeen <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      xferDone <= (state_ff == `BAS_ST_OWNREPLY) && (nxt_state == `BAS_ST_IDLE);
      exceptionSeen <= (nxt_state == `BAS_ST_SIGNAL) && (state_ff != `BAS_ST_SIGNAL);
      cnt_ff <= (nxt_state != state_ff) ? {`BAS_CNT_W{1'b0}} : cnt_ff + 1'b1;
      if (state_ff == `BAS_ST_IDLE) begin
        addr_ff <= xferAddr;
      end
      // Owner: four-phase handshake, data held until replier answers
      if (state_ff == `BAS_ST_OWNREPLY) begin
        if (!phase_ff && fifoPop) begin
          phase_ff <= 1'b1;
        end else if (phase_ff && !sRrdy) begin
          phase_ff <= 1'b0;
        end
      end else if (state_ff != `BAS_ST_RXREPLY) begin
        phase_ff <= 1'b0;
      end
      // Replier: answer owner ready as soon as rxValid is clear, in the cycle the word is captured
      if (state_ff == `BAS_ST_RXREPLY) begin
        if (sOrdy && !rrdy_ff && !rxValid) begin
          rrdy_ff <= 1'b1;
          phase_ff <= 1'b1;
          drvErr_ff <= parErr; // [RL15]
        end else if (!sOrdy) begin
          rrdy_ff <= 1'b0;
        end
      end else begin
        rrdy_ff <= 1'b0;
      end
      // Error line held for the signal phase, then released
      if (state_ff == `BAS_ST_SIGNAL && cnt_ff >= SIGNAL_CYC) begin
        drvErr_ff <= 1'b0; // [RL11]
      end
    end
  end

  // Owner-side line drivers, loaded from flops
  always @(posedge clk) begin
    if (!rst_n) begin
      startOut <= 1'b0;
      spaceOut <= `BAS_SP_MEM;
      writeOut <= 1'b0;
      eotOut <= 1'b0;
      ownerRdyOut <= 1'b0;
      adOut <= {DATA_W{1'b0}};
    end else begin
      startOut <= (nxt_state == `BAS_ST_REQUEST); // [RL8]
      writeOut <= (nxt_state == `BAS_ST_REQUEST) || (nxt_state == `BAS_ST_OWNREPLY);
      if (nxt_state == `BAS_ST_REQUEST) begin
        adOut <= addr_ff;
        spaceOut <= xferSpace;
        eotOut <= 1'b0;
      end else if (state_ff == `BAS_ST_OWNREPLY && !phase_ff && !ownerRdyOut && !sRrdy &&
                   fifoValid) begin
        adOut <= fifoOut[DATA_W-1:0]; // [RL12] [RL3]
        eotOut <= fifoOut[DATA_W]; // [RL9]
        ownerRdyOut <= 1'b1;
      end else if (fifoPop || nxt_state != `BAS_ST_OWNREPLY) begin
        ownerRdyOut <= 1'b0;
      end
    end
  end

  // Received words go to the host; valid holds until taken
  always @(posedge clk) begin
    if (!rst_n) begin
      rxData <= {DATA_W{1'b0}};
      rxSpace <= `BAS_SP_MEM;
      rxLast <= 1'b0;
      rxValid <= 1'b0;
    end else begin
      if (state_ff == `BAS_ST_IDLE && rxHit) begin
        rxSpace <= sSpace;
      end
      if (state_ff == `BAS_ST_RXREPLY && sOrdy && !rrdy_ff && !rxValid && !parErr) begin
        rxData <= sAd; // [RL3]
        rxLast <= sEot;
        rxValid <= 1'b1;
      end else if (rxReady) begin
        rxValid <= 1'b0;
      end
    end
  end

  // Host address decode into the four spaces
  always @(posedge clk) begin
    if (!rst_n) begin
      csMem <= 1'b0;
      csIo <= 1'b0;
      csMsg <= 1'b0;
      csIcn <= 1'b0;
    end else begin
      csMsg <= !hostIo && (hostAddr[DATA_W-1:8] == `BAS_HOST_MSG_PAGE); // [RL6]
      csIcn <= !hostIo && (hostAddr[DATA_W-1:16] == `BAS_HOST_ICN_PAGE); // [RL6]
      csMem <= !hostIo && (hostAddr[DATA_W-1:8] != `BAS_HOST_MSG_PAGE) &&
               (hostAddr[DATA_W-1:16] != `BAS_HOST_ICN_PAGE);
      csIo <= hostIo;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Open-drain drivers; all released outside our own phases
  assign sharedBusRequestNOut = 1'b0;
  assign sharedBusRequestNOe = (state_ff == `BAS_ST_RESOLVE); // [RL13] [RL17]
  assign arbitrationIdLinesOut = arbId;
  assign arbitrationIdLinesOe = (state_ff == `BAS_ST_RESOLVE) ? arbId : 5'h00; // [RL14]
  assign busErrorNOut = 1'b0;
  assign busErrorNOe = drvErr_ff; // [RL15]
  assign ownerLinesOe = (state_ff == `BAS_ST_REQUEST) ||
                        (state_ff == `BAS_ST_OWNREPLY); // [RL17]
  assign replierRdyOut = rrdy_ff;
  assign replierRdyOe = (state_ff == `BAS_ST_RXREPLY);
  assign xferAck = (state_ff == `BAS_ST_ACQUIRE);
  assign state = state_ff;
endmodule // bas_sequencer

`default_nettype wire

// ===== bas_seq_asserts.sv
// Checker for the agent sequencer: bus-side ordering, drives and exception handling
`default_nettype none

module bas_seq_asserts #(
  parameter DATA_W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic xferReq,
  input wire logic busTimeoutNIn,
  input wire logic [2:0] state,
  input wire logic xferAck,
  input wire logic startOut,
  input wire logic ownerLinesOe,
  input wire logic sharedBusRequestNOe,
  input wire logic sharedBusRequestNOut,
  input wire logic [4:0] arbitrationIdLinesOe,
  input wire logic [4:0] arbId,
  input wire logic replierRdyOe,
  input wire logic exceptionSeen,
  input wire logic ownerRdyOut,
  input wire logic [DATA_W-1:0] adOut,
  input wire logic [3:0] parOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Arbitration: acquisition only follows resolution, and grants only a live request
  a_acq_after_res: assert property (state == 3'h2 |-> $past(state) == 3'h1)
    else $error("acquire entered without resolve");
  a_ack_in_acquire: assert property (xferAck |-> state == 3'h2 && xferReq)
    else $error("ack outside acquire or without request");
  a_start_request: assert property (xferAck |=> startOut && ownerLinesOe && state == 3'h3)
    else $error("no request phase after ack");
  // Contention lines are driven only while resolving
  a_req_line: assert property (sharedBusRequestNOe |-> !sharedBusRequestNOut && state == 3'h1)
    else $error("request line driven outside resolve");
  a_arb_drive: assert property (|arbitrationIdLinesOe |-> state == 3'h1 && arbitrationIdLinesOe == arbId)
    else $error("arbitration lines carry wrong id");
  // Exceptions: owner, request, id and replier drives released, phases held, no direct return to arbitration
  a_exc_release: assert property ((state == 3'h6 || state == 3'h7) |->
    !ownerLinesOe && !sharedBusRequestNOe && arbitrationIdLinesOe == 5'h00 && !replierRdyOe)
    else $error("driver left on during exception");
  a_exc_any: assert property ((!busTimeoutNIn) [*5] |-> state == 3'h6 || state == 3'h7)
    else $error("timeout did not abort the cycle");
  a_signal_hold: assert property (exceptionSeen |-> (state == 3'h6) [*2])
    else $error("signal phase too short");
  a_recover_exit: assert property (state == 3'h7 |=> state inside {3'h7, 3'h0, 3'h6})
    else $error("recovery left to a busy state");
  // Byte parity follows the driven word
  a_par_owner: assert property (ownerLinesOe && ownerRdyOut |->
    parOut == {^adOut[31:24], ^adOut[23:16], ^adOut[15:8], ^adOut[7:0]})
    else $error("owner parity wrong");
endmodule // bas_seq_asserts

bind bas_sequencer bas_seq_asserts #(.DATA_W(DATA_W)) u_chk (
  .clk(clk), .rst_n(rst_n), .xferReq(xferReq), .busTimeoutNIn(busTimeoutNIn), .state(state),
  .xferAck(xferAck), .startOut(startOut), .ownerLinesOe(ownerLinesOe),
  .sharedBusRequestNOe(sharedBusRequestNOe), .sharedBusRequestNOut(sharedBusRequestNOut),
  .arbitrationIdLinesOe(arbitrationIdLinesOe), .arbId(arbId), .replierRdyOe(replierRdyOe),
  .exceptionSeen(exceptionSeen), .ownerRdyOut(ownerRdyOut), .adOut(adOut), .parOut(parOut)
);

`default_nettype wire

// ===== bas_far_agent.sv
// Far side: backplane wiring, a slow replier, a competitor and the timeout source
`default_nettype none

module bas_far_agent (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] stall,
  input wire logic [4:0] compId,
  input wire logic compReq,
  input wire logic toReq,
  input wire logic reqOe,
  input wire logic reqOut,
  input wire logic [4:0] arbOut,
  input wire logic [4:0] arbOe,
  input wire logic errOe,
  input wire logic errOut,
  input wire logic ownRdy,
  input wire logic [31:0] ad,
  input wire logic eot,
  input wire logic rdyOut,
  input wire logic rdyOe,
  output logic reqN,
  output logic [4:0] arb,
  output logic errN,
  output logic toN,
  output logic rdy,
  output logic wordStb,
  output logic [31:0] wordData,
  output logic wordEot
);
  logic farRdy;
  logic [3:0] waitCnt;

  // Pulled-up request line, also pulled by the competitor
  assign reqN = (reqOe ? reqOut : 1'b1) & ~compReq;
  // Wired-OR ids; ids are also placed here while identifiers are read after reset
  assign arb = (arbOut & arbOe) | compId;
  assign errN = errOe ? errOut : 1'b1;
  assign toN = ~toReq;
  // Replier line has a pull-down, so it reads low when nobody drives it
  assign rdy = farRdy | (rdyOe & rdyOut);

  // Four-phase replier: answer after stall cycles, drop once the owner lets go
  always @(posedge clk) begin
    wordStb <= 1'b0;
    if (!rst_n || !errN || !toN) begin
      farRdy <= 1'b0;
      waitCnt <= 4'h0;
    end else if (!farRdy && ownRdy) begin
      if (waitCnt == stall) begin
        farRdy <= 1'b1;
        wordStb <= 1'b1;
        wordData <= ad;
        wordEot <= eot;
        waitCnt <= 4'h0;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end else if (farRdy && !ownRdy) begin
      farRdy <= 1'b0;
    end
  end
endmodule // bas_far_agent

`default_nettype wire

// ===== tb_backplane_agent_cycle_sequencer.sv
// Testbench for the agent sequencer against a far-side model
`default_nettype none

module tb_backplane_agent_cycle_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, xferReq, txValid, txLast, rxReady, hostIo, tStart, tWrite, tEot, tRdy;
  logic compReq, toReq, reqNOut, reqNOe, errNOut, errNOe, startO, writeO, eotO, ownRdyO, lineOe;
  logic rdyO, rdyOe, xferAck, txReady, rxLast, rxValid, csMem, csIo, csMsg, csIcn, idReady;
  logic xferDone, excSeen, reqN, errN, toN, rdyL, wStb, wEot;
  logic [1:0] tSpace, xferSpace, spaceO, rxSpace;
  logic [2:0] state;
  logic [3:0] tPar, parO, stall;
  logic [4:0] arbOut, arbOe, slotId, arbId, compId, arbL;
  logic [31:0] xferAddr, txData, hostAddr, tAd, adO, rxData, wData;
  logic [32:0] expQ[$], gotQ[$];
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;

  bas_sequencer dut_u (
    .clk(clk), .rst_n(rst_n), .sharedBusRequestNIn(reqN), .sharedBusRequestNOut(reqNOut),
    .sharedBusRequestNOe(reqNOe), .arbitrationIdLinesIn(arbL), .arbitrationIdLinesOut(arbOut),
    .arbitrationIdLinesOe(arbOe), .busErrorNIn(errN), .busErrorNOut(errNOut),
    .busErrorNOe(errNOe), .busTimeoutNIn(toN), .startIn(lineOe ? startO : tStart),
    .spaceIn(lineOe ? spaceO : tSpace), .writeIn(lineOe ? writeO : tWrite),
    .eotIn(lineOe ? eotO : tEot), .ownerRdyIn(lineOe ? ownRdyO : tRdy),
    .adIn(lineOe ? adO : tAd), .parIn(lineOe ? parO : tPar), .startOut(startO),
    .spaceOut(spaceO), .writeOut(writeO), .eotOut(eotO), .ownerRdyOut(ownRdyO), .adOut(adO),
    .parOut(parO), .ownerLinesOe(lineOe), .replierRdyIn(rdyL), .replierRdyOut(rdyO),
    .replierRdyOe(rdyOe), .xferReq(xferReq), .xferAddr(xferAddr), .xferSpace(xferSpace),
    .xferAck(xferAck), .txData(txData), .txLast(txLast), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxSpace(rxSpace), .rxLast(rxLast), .rxValid(rxValid), .rxReady(rxReady),
    .hostAddr(hostAddr), .hostIo(hostIo), .csMem(csMem), .csIo(csIo), .csMsg(csMsg),
    .csIcn(csIcn), .slotId(slotId), .arbId(arbId), .idReady(idReady), .xferDone(xferDone),
    .exceptionSeen(excSeen), .state(state)
  );

  bas_far_agent far_u (
    .clk(clk), .rst_n(rst_n), .stall(stall), .compId(compId), .compReq(compReq),
    .toReq(toReq), .reqOe(reqNOe), .reqOut(reqNOut), .arbOut(arbOut), .arbOe(arbOe),
    .errOe(errNOe), .errOut(errNOut), .ownRdy(lineOe & ownRdyO), .ad(adO), .eot(eotO),
    .rdyOut(rdyO), .rdyOe(rdyOe), .reqN(reqN), .arb(arbL), .errN(errN), .toN(toN),
    .rdy(rdyL), .wordStb(wStb), .wordData(wData), .wordEot(wEot)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, received-word log and a hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wStb) gotQ.push_back({wEot, wData});
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Inputs move a fixed 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic waitSt(input logic [2:0] s, input int max);
    for (int i = 0; i < max && state !== s; i++) step(1);
    chk(33'(state), 33'(s), "state wait");
  endtask

  function automatic logic [3:0] par4(input logic [31:0] d);
    return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  // Write n random words; optionally a higher-id competitor first
  task automatic burst(input int n, input logic [3:0] st, input logic comp);
    int hits;
    int tries;
    gotQ.delete();
    expQ.delete();
    stall = st;
    for (int i = 0; i < n; i++) begin
      expQ.push_back({1'(i == n - 1), 32'($urandom())});
      {txLast, txData} = expQ[i];
      txValid = 1'b1;
      for (tries = 0; tries < 50 && txReady !== 1'b1; tries++) step(1);
      step(1);
    end
    txValid = 1'b0;
    if (n == 32) chk(33'(txReady), 33'h0, "fifo not full");
    xferAddr = $urandom();
    xferSpace = 2'($urandom_range(3, 0));
    xferReq = 1'b1;
    if (comp) begin
      compId = 5'h1c;
      compReq = 1'b1;
      hits = 0;
      for (int i = 0; i < 40; i++) begin
        step(1);
        if (state === 3'h2) hits++;
      end
      chk(33'(hits), 33'h0, "won against higher id");
      compId = 5'h00;
      compReq = 1'b0;
    end
    waitSt(3'h2, 100);
    chk(33'(xferAck), 33'h1, "no ack in acquire");
    step(1);
    xferReq = 1'b0;
    chk(33'({state, startO, lineOe}), 33'h0f, "no request phase");
    for (tries = 0; tries < 3000 && xferDone !== 1'b1; tries++) step(1);
    chk(33'(xferDone), 33'h1, "burst not done");
    chk(33'(gotQ.size()), 33'(n), "word count");
    for (int i = 0; i < n && i < gotQ.size(); i++) chk(gotQ[i], expQ[i], "word");
  endtask

  task automatic dec(input logic [31:0] a, input logic io, input logic [3:0] exp);
    hostAddr = a;
    hostIo = io;
    step(1);
    chk(33'({csMem, csIo, csMsg, csIcn}), 33'(exp), "decode");
  endtask

  // Inbound transfer: header, then one word, good or bad parity
  task automatic rxXfer(input logic [1:0] sp, input logic [31:0] a, input logic bad);
    logic [31:0] d;
    d = $urandom();
    {tStart, tSpace, tWrite, tAd} = {1'b1, sp, 1'b1, a};
    step(1);
    tStart = 1'b0;
    step(3);
    {tAd, tPar, tEot, tRdy} = {d, par4(d) ^ {3'h0, bad}, 1'b1, 1'b1};
    for (int i = 0; i < 20 && (bad ? errNOe : rdyO & rdyOe) !== 1'b1; i++) step(1);
    if (bad) begin
      chk(33'(errNOe), 33'h1, "no bus error");
      tRdy = 1'b0;
    end else begin
      chk(33'(rdyO & rdyOe), 33'h1, "no replier handshake");
      tRdy = 1'b0;
      for (int i = 0; i < 20 && rxValid !== 1'b1; i++) step(1);
      chk({1'b0, rxData}, {1'b0, d}, "rx data");
      step(3);
      chk(33'({rxValid, rxSpace, rxLast}), 33'({1'b1, sp, 1'b1}), "rx hold");
      rxReady = 1'b1;
      step(1);
      rxReady = 1'b0;
    end
    waitSt(3'h0, 60);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h3cd9));
    {rst_n, xferReq, txValid, txLast, rxReady, hostIo, tStart, tWrite, tEot, tRdy} = '0;
    {compReq, toReq, tSpace, xferSpace, tPar, stall, xferAddr, txData, hostAddr, tAd} = '0;
    compId = 5'h03;
    step(16);
    chk(33'({reqNOe, arbOe, errNOe, lineOe, rdyOe}), 33'h0, "drive in reset");
    rst_n = 1'b1;
    step(1);
    compId = 5'h0a;
    step(1);
    compId = 5'h00;
    for (int i = 0; i < 20 && idReady !== 1'b1; i++) step(1);
    chk(33'({idReady, slotId, arbId}), 33'h46a, "ids after reset");
    burst($urandom_range(8, 2), 4'($urandom_range(5, 0)), 1'b0);
    burst(32, 4'h3, 1'b1);
    burst(1, 4'h0, 1'b0);
    dec({8'h01, 24'($urandom())}, 1'b0, 4'b1000);
    dec({8'h00, 24'($urandom())}, 1'b1, 4'b0100);
    dec(32'hfffe_00ff, 1'b0, 4'b0010);
    dec(32'hfffe_0100, 1'b0, 4'b1000);
    dec(32'hfffd_f800, 1'b0, 4'b0001);
    rxXfer(2'h3, {16'h0, 5'h03, 11'h000}, 1'b0);
    rxXfer(2'h2, 32'h0000_00ff, 1'b0);
    rxXfer(2'h2, 32'h0000_0005, 1'b1);
    // Timeout mid-burst: abort, release, recover
    expQ.delete();
    for (int i = 0; i < 4; i++) begin
      {txLast, txData} = {1'(i == 3), 32'($urandom())};
      txValid = 1'b1;
      step(1);
    end
    txValid = 1'b0;
    stall = 4'hf;
    xferReq = 1'b1;
    waitSt(3'h2, 100);
    step(1);
    xferReq = 1'b0;
    step(12);
    toReq = 1'b1;
    for (int i = 0; i < 10 && excSeen !== 1'b1; i++) step(1);
    chk(33'({excSeen, state, lineOe, reqNOe}), 33'h38, "no abort on timeout");
    step(4);
    toReq = 1'b0;
    waitSt(3'h0, 40);
    give_verdict();
  end
endmodule // tb_backplane_agent_cycle_sequencer

`default_nettype wire
